/* verilog/dac_ovr_consts.svh */
`ifndef DAC_OVR_CONSTS_SVH
`define DAC_OVR_CONSTS_SVH
`define FRAME_BITS       32
`define CMD_HI           27
`define CMD_LO           24
`define ADDR_HI          23
`define ADDR_LO          20
`define CMD_LOAD_OVR     4'h6
`define CMD_WRITE_IN     4'h0
`define CMD_WRITE_UPD_N  4'h3
`define CMD_WRITE_UPD_A  4'h2
`define DATA_HI          19
`define DATA_LO          4
`define OVR_RESET        4'h0
`define CHANNELS         4
`endif

/* verilog/dac_ovr_pkg.sv */
`default_nettype none
package dac_ovr_pkg;
  typedef logic [3:0]  nibble_t;
  typedef logic [15:0] code_t;
endpackage
`default_nettype wire

/* verilog/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic rst_val,
  // Pin
  input  wire logic pin_in,
  output logic      pin_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  // Reset value is a constant at each instance
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta_q <= rst_val;
      sync_q <= rst_val;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_out = sync_q;
endmodule // pin_sync
`default_nettype wire

/* verilog/dac_load_override_serial_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dac_ovr_consts.svh"
module dac_load_override_serial_control
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // Serial link pins
  input  wire logic                 frame_sel_n,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_din,
  input  wire logic                 load_strobe_pin_n,
  // Channel outputs
  output logic [63:0]               dac_code,
  output dac_ovr_pkg::nibble_t      channel_load_override,
  output logic                      word_done
);
  logic                 fs_n;
  logic                 sck;
  logic                 din;
  logic                 ld_n;
  logic                 sck_q;
  logic                 sck_d;
  logic [31:0]          shift_q;
  logic [31:0]          shift_d;
  logic [5:0]           cnt_q;
  logic [5:0]           cnt_d;
  dac_ovr_pkg::nibble_t ovr_q;
  dac_ovr_pkg::nibble_t ovr_d;
  dac_ovr_pkg::code_t   in_q  [4];
  dac_ovr_pkg::code_t   in_d  [4];
  dac_ovr_pkg::code_t   dac_q [4];
  dac_ovr_pkg::code_t   dac_d [4];
  logic                 done_q;
  logic                 done_d;
  logic                 fall;
  logic [31:0]          word;
  logic [3:0]           cmd;
  logic [3:0]           addr;

  // Pins come from outside this clock; two flops each
  pin_sync u_fs
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .rst_val (1'b1),
    .pin_in  (frame_sel_n),
    .pin_out (fs_n)
  );
  pin_sync u_sck
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .rst_val (1'b0),
    .pin_in  (serial_clk),
    .pin_out (sck)
  );
  pin_sync u_din
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .rst_val (1'b0),
    .pin_in  (serial_din),
    .pin_out (din)
  );
  pin_sync u_ld
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .rst_val (1'b1),
    .pin_in  (load_strobe_pin_n),
    .pin_out (ld_n)
  );

  assign fall = sck_q && !sck;
  assign word = {shift_q[30:0], din};
  assign cmd  = word[`CMD_HI:`CMD_LO];
  assign addr = word[`ADDR_HI:`ADDR_LO];

  always_comb
  begin
    sck_d   = sck;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    ovr_d   = ovr_q;
    done_d  = 1'b0;
    for (int i = 0; i < `CHANNELS; i++)
    begin
      in_d[i]  = in_q[i];
      dac_d[i] = dac_q[i];
    end
    if (fs_n)
    begin
      cnt_d = 6'h00;
    end
    else if (fall && cnt_q < 6'(`FRAME_BITS))
    begin
      shift_d = word;
      cnt_d   = cnt_q + 6'h01;
      if (cnt_q == 6'(`FRAME_BITS - 1))
      begin
        done_d = 1'b1;
        if (cmd == `CMD_LOAD_OVR)
        begin
          ovr_d = word[3:0];
        end
        else if (cmd == `CMD_WRITE_IN || cmd == `CMD_WRITE_UPD_N
                 || cmd == `CMD_WRITE_UPD_A)
        begin
          for (int i = 0; i < `CHANNELS; i++)
          begin
            if (addr[i] || addr == 4'hf)
            begin
              in_d[i] = word[`DATA_HI:`DATA_LO];
              // Overridden channels behave as if the strobe were tied low
              if (ovr_q[i] || !ld_n)
              begin
                dac_d[i] = word[`DATA_HI:`DATA_LO];
              end
            end
          end
        end
      end
    end
    for (int i = 0; i < `CHANNELS; i++)
    begin
      // Strobe is a level: while low it keeps copying; a completing word wins
      if (!ld_n && !ovr_q[i] && !done_d)
      begin
        dac_d[i] = in_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sck_q   <= 1'b0;
      shift_q <= 32'h0;
      cnt_q   <= 6'h00;
      ovr_q   <= `OVR_RESET;
      done_q  <= 1'b0;
      for (int i = 0; i < `CHANNELS; i++)
      begin
        in_q[i]  <= 16'h0;
        dac_q[i] <= 16'h0;
      end
    end
    else
    begin
      sck_q   <= sck_d;
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      ovr_q   <= ovr_d;
      done_q  <= done_d;
      for (int i = 0; i < `CHANNELS; i++)
      begin
        in_q[i]  <= in_d[i];
        dac_q[i] <= dac_d[i];
      end
    end
  end

  assign dac_code              = {dac_q[3], dac_q[2], dac_q[1], dac_q[0]};
  assign channel_load_override = ovr_q;
  assign word_done             = done_q;

  sequence last_edge_s;
    !fs_n && fall && cnt_q == 6'd31;
  endsequence

  sequence write_cmd_s;
    cmd == `CMD_WRITE_IN || cmd == `CMD_WRITE_UPD_N || cmd == `CMD_WRITE_UPD_A;
  endsequence

  ovr_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    last_edge_s ##0 (cmd == 4'h6) |=> ovr_q == $past(word[3:0]))
    else $error("override bits not loaded");
  ovr_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fs_n |=> $stable(ovr_q) && cnt_q == 6'd0)
    else $error("activity while frame select high");
  done_at_32_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    word_done |-> $past(cnt_q) == 6'd31 && cnt_q == 6'd32)
    else $error("word acted on at wrong edge");
  ovr_other_cmd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    last_edge_s ##0 (cmd != 4'h6) |=> $stable(ovr_q))
    else $error("override changed by other command");
  ovr_reset_a: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> ovr_q == 4'h0)
    else $error("override not cleared at reset");
  strobe_copy_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ld_n && !ovr_q[0] && !done_d |=> dac_q[0] == $past(in_q[0]))
    else $error("strobe did not copy input register");
  pin_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ld_n && !ovr_q[1] && !done_d |=> $stable(dac_q[1]))
    else $error("pin controlled channel changed without strobe");
  ovr_upd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    last_edge_s ##0 (cmd == 4'h3 && addr[2] && ovr_q[2])
    |=> dac_q[2] == in_q[2])
    else $error("overridden channel not updated");
  ovr_data_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    last_edge_s ##0 write_cmd_s ##0 (addr[0] && ovr_q[0])
    |=> dac_q[0] == $past(word[`DATA_HI:`DATA_LO]))
    else $error("overridden channel missed new data");
  shift_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fs_n |=> $stable(shift_q))
    else $error("shift register moved while frame select high");
endmodule // dac_load_override_serial_control
`default_nettype wire

/* dv/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Clock
  input  wire logic sys_clk,
  // Serial link
  output logic      frame_sel_n,
  output logic      serial_clk,
  output logic      serial_din
);
  initial
  begin
    frame_sel_n = 1'b1;
    serial_clk  = 1'b0;
    serial_din  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Data changes on the rise and is held across the fall, 160 ns per bit
  task automatic send(input logic [31:0] w, input logic bytes, input logic sel);
    frame_sel_n = ~sel;
    tick(2);
    for (int i = 31; i >= 0; i--)
    begin
      serial_din = w[i];
      serial_clk = 1'b1;
      tick(4);
      serial_clk = 1'b0;
      tick(4);
      if (bytes && (i % 8 == 0))
        tick(8);
    end
    tick(2);
    frame_sel_n = 1'b1;
    // Released line must not keep showing the last bit
    serial_din  = ~serial_din;
    tick(8);
  endtask
endmodule // host_model
`default_nettype wire

/* dv/dac_load_override_serial_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_load_override_serial_control_tb;
  logic                 sys_clk  = 1'b0;
  logic                 sys_rst  = 1'b1;
  logic                 strobe_n = 1'b1;
  wire logic            fs_n;
  wire logic            sck;
  wire logic            din;
  logic [63:0]          code;
  dac_ovr_pkg::nibble_t ovr;
  logic                 done;
  int                   err_count = 0;
  int                   n_checks  = 0;
  int                   n_done    = 0;

  always #10 sys_clk = ~sys_clk;

  host_model i_host_model
  (
    .sys_clk     (sys_clk),
    .frame_sel_n (fs_n),
    .serial_clk  (sck),
    .serial_din  (din)
  );

  dac_load_override_serial_control i_dac_load_override_serial_control
  (
    .sys_clk               (sys_clk),
    .sys_rst               (sys_rst),
    .frame_sel_n           (fs_n),
    .serial_clk            (sck),
    .serial_din            (din),
    .load_strobe_pin_n     (strobe_n),
    .dac_code              (code),
    .channel_load_override (ovr),
    .word_done             (done)
  );

  always @(posedge sys_clk)
    if (done === 1'b1)
      n_done++;

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  // Strobe is held long enough to pass the pin synchroniser
  task automatic strobe;
    strobe_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    strobe_n = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    results;
  end

  initial
  begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("override", 64'h0, ovr);
    chk("code", 64'h0, code);
    $display("test reset done");
    i_host_model.send({8'h00, 4'h1, 16'h1234, 4'h0}, 1'b0, 1'b1);
    chk("code", 64'h0, code);
    strobe();
    chk("code", 64'h1234, code);
    $display("test strobe done");
    i_host_model.send(32'hf6ff_fff5, 1'b1, 1'b1);
    chk("override", 64'h5, ovr);
    i_host_model.send(32'h06f0_000a, 1'b0, 1'b0);
    chk("override", 64'h5, ovr);
    $display("test override done");
    i_host_model.send({4'h0, 4'h3, 4'hf, 16'habcd, 4'h0}, 1'b0, 1'b1);
    chk("code", 64'h0000abcd0000abcd, code);
    chk("words", 64'd3, n_done);
    strobe();
    chk("code", 64'habcdabcdabcdabcd, code);
    $display("test mixed update done");
    results;
  end
endmodule // dac_load_override_serial_control_tb
`default_nettype wire
